// >>> rtl/htc_timer.sv
// Purpose: 16-bit up/down timer/counter with compare, PWM, capture and APB registers
// Assumes: ref_clk 250 MHz; timer_clock_in, timer_reset_n, capture_trigger_in are asynchronous pins
// Notes:   STANDALONE=1 freezes control, top and compare at their preload parameters
// Function
// [RQ1] sixteen-bit counter counts up or down as the mode needs
// [RQ2] modes: watchdog, clear on compare match, fast pwm, phase-frequency correct pwm
// [RQ3] count clock source selectable, then divided by a programmable prescaler
// [RQ4] three interrupt causes: overflow, compare match, input capture
// [RQ5] one static interrupt output and one separate wake-up interrupt output
// [RQ6] capture: synchronised rising edge copies count into capture register, non-pwm modes
// [RQ7] stand-alone: interrupt output serves as overflow flag
// [RQ8] with bus: interrupt output governed by status, mask and set registers
// [RQ9] reset pin enable preloaded so the active-low reset pin always works
// [RQ10] glitch-free pwm with variable period, period changes take effect cleanly
// [RQ11] output compare drives the generated waveform onto the timer output
// [RQ12] registers reachable by bus master, or stand-alone from preloaded settings
// [RQ13] counter reloads automatically at every period end
// [RQ14] capture trigger passes two synchroniser stages before edge detection
`timescale 1ns/1ps
`default_nettype none
module htc_timer #(
    parameter bit          STANDALONE   = 1'b0,
    parameter logic [10:0] PRELOAD_CTRL = 11'h080,
    parameter logic [15:0] PRELOAD_TOP  = 16'hffff,
    parameter logic [15:0] PRELOAD_CMP  = 16'h8000
) (
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        timer_clock_in,
    input  wire logic        timer_reset_n,
    input  wire logic        capture_trigger_in,
    output logic             timer_irq_out,
    output logic             wake_irq_out,
    output logic             compare_wave_out
);
    localparam logic [10:0] CTRL_INIT = STANDALONE ? PRELOAD_CTRL : htc_pkg::CTRL_RST;
    localparam logic [15:0] TOP_INIT  = STANDALONE ? PRELOAD_TOP : htc_pkg::TOP_RST;
    localparam logic [15:0] CMP_INIT  = STANDALONE ? PRELOAD_CMP : htc_pkg::CMP_RST;

    // pin synchronisers: bit 0 clock pin, bit 1 reset pin, bit 2 capture pin
    logic [2:0] sync1_r;
    logic [2:0] sync2_r;
    logic [2:0] sync3_r;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync1_r <= 3'h2;
            sync2_r <= 3'h2;
            sync3_r <= 3'h2;
        end else begin
            sync1_r <= {capture_trigger_in, timer_reset_n, timer_clock_in}; // RQ14
            sync2_r <= sync1_r; // RQ14
            sync3_r <= sync2_r;
        end
    end

    logic clk_rise;
    logic cap_rise;
    assign clk_rise = sync2_r[0] & ~sync3_r[0];
    assign cap_rise = sync2_r[2] & ~sync3_r[2]; // RQ6

    // bus-side register group
    htc_pkg::htc_ctrl_type ctrl_r, ctrl_nxt;
    logic [15:0]           top_buf_r, top_buf_nxt;
    logic [15:0]           cmp_buf_r, cmp_buf_nxt;
    logic [2:0]            mask_r, mask_nxt;
    logic                  rst_pin_en_r;
    logic                  pready_r, pready_nxt;
    logic                  pslverr_r, pslverr_nxt;
    logic [31:0]           prdata_r, prdata_nxt;

    // counter group
    logic [15:0]           cnt_r, cnt_nxt;
    logic [15:0]           top_act_r, top_act_nxt;
    logic [15:0]           cmp_act_r, cmp_act_nxt;
    logic [15:0]           cap_r, cap_nxt;
    logic [9:0]            psc_r, psc_nxt;
    logic                  down_r, down_nxt;
    logic                  wave_r, wave_nxt;
    htc_pkg::htc_irq_type  stat_r, stat_nxt;
    logic                  irq_r, irq_nxt;
    logic                  wake_r, wake_nxt;

    logic wr_acc;
    logic rd_acc;
    logic addr_ok;
    logic pin_rst;
    assign wr_acc  = psel & penable & pready_r & pwrite;
    assign rd_acc  = psel & penable & ~pready_r & ~pwrite;
    assign pin_rst = rst_pin_en_r & ~sync2_r[1]; // RQ9

    always_comb begin
        case (paddr)
            htc_pkg::OFS_CTRL, htc_pkg::OFS_TOP, htc_pkg::OFS_CMP, htc_pkg::OFS_COUNT,
            htc_pkg::OFS_CAPTURE, htc_pkg::OFS_IRQ_STAT, htc_pkg::OFS_IRQ_MASK,
            htc_pkg::OFS_IRQ_SET, htc_pkg::OFS_STATUS: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    // apb slave: one wait state, read data captured on the first access cycle
    always_comb begin
        ctrl_nxt    = ctrl_r;
        top_buf_nxt = top_buf_r;
        cmp_buf_nxt = cmp_buf_r;
        mask_nxt    = mask_r;
        pready_nxt  = psel & penable & ~pready_r;
        pslverr_nxt = psel & penable & ~pready_r & ~addr_ok;
        prdata_nxt  = prdata_r;
        if (rd_acc) begin
            case (paddr)
                htc_pkg::OFS_CTRL:     prdata_nxt = {20'h00000, rst_pin_en_r, ctrl_r};
                htc_pkg::OFS_TOP:      prdata_nxt = {16'h0000, top_buf_r};
                htc_pkg::OFS_CMP:      prdata_nxt = {16'h0000, cmp_buf_r};
                htc_pkg::OFS_COUNT:    prdata_nxt = {16'h0000, cnt_r};
                htc_pkg::OFS_CAPTURE:  prdata_nxt = {16'h0000, cap_r};
                htc_pkg::OFS_IRQ_STAT: prdata_nxt = {29'h00000000, stat_r};
                htc_pkg::OFS_IRQ_MASK: prdata_nxt = {29'h00000000, mask_r};
                htc_pkg::OFS_STATUS:   prdata_nxt = {30'h00000000, ctrl_r.run, down_r};
                default:               prdata_nxt = 32'h00000000;
            endcase
        end
        if (wr_acc && !STANDALONE) begin // RQ12
            case (paddr)
                htc_pkg::OFS_CTRL:     ctrl_nxt    = pwdata[htc_pkg::CTRL_W-1:0];
                htc_pkg::OFS_TOP:      top_buf_nxt = pwdata[15:0];
                htc_pkg::OFS_CMP:      cmp_buf_nxt = pwdata[15:0];
                htc_pkg::OFS_IRQ_MASK: mask_nxt    = pwdata[2:0]; // RQ8
                default:               ctrl_nxt    = ctrl_r;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_r       <= CTRL_INIT;
            top_buf_r    <= TOP_INIT;
            cmp_buf_r    <= CMP_INIT;
            mask_r       <= htc_pkg::IRQ_RST;
            rst_pin_en_r <= 1'b1; // RQ9
            pready_r     <= 1'b0;
            pslverr_r    <= 1'b0;
            prdata_r     <= 32'h00000000;
        end else begin
            ctrl_r       <= ctrl_nxt;
            top_buf_r    <= top_buf_nxt;
            cmp_buf_r    <= cmp_buf_nxt;
            mask_r       <= mask_nxt;
            rst_pin_en_r <= 1'b1;
            pready_r     <= pready_nxt;
            pslverr_r    <= pslverr_nxt;
            prdata_r     <= prdata_nxt;
        end
    end

    // counter engine
    logic                 pwm;
    logic                 src_tick;
    logic                 tick;
    logic                 period_end;
    logic [3:0]           sel_c;
    logic [9:0]           psc_mask;
    logic                 cnt_wr;
    logic                 sw_clr;
    htc_pkg::htc_irq_type ev;
    htc_pkg::htc_irq_type w1c;
    htc_pkg::htc_irq_type setv;

    assign pwm      = (ctrl_r.mode == htc_pkg::HTC_MODE_FPWM) || (ctrl_r.mode == htc_pkg::HTC_MODE_PFC);
    assign src_tick = ctrl_r.clk_src ? clk_rise : 1'b1; // RQ3
    assign sel_c    = (ctrl_r.psc_sel > htc_pkg::PSC_SEL_MAX) ? htc_pkg::PSC_SEL_MAX : ctrl_r.psc_sel;
    assign psc_mask = 10'((11'h001 << sel_c) - 11'h001);
    assign tick     = ctrl_r.run & src_tick & ((psc_r & psc_mask) == psc_mask); // RQ3
    assign cnt_wr   = wr_acc && (paddr == htc_pkg::OFS_COUNT);
    assign sw_clr   = wr_acc && (paddr == htc_pkg::OFS_CTRL) && pwdata[htc_pkg::CTRL_CLR_BIT];
    assign w1c      = (wr_acc && (paddr == htc_pkg::OFS_IRQ_STAT)) ? pwdata[2:0] : 3'h0;
    assign setv     = (wr_acc && (paddr == htc_pkg::OFS_IRQ_SET)) ? pwdata[2:0] : 3'h0;

    always_comb begin
        cnt_nxt     = cnt_r;
        down_nxt    = down_r;
        top_act_nxt = top_act_r;
        cmp_act_nxt = cmp_act_r;
        cap_nxt     = cap_r;
        psc_nxt     = psc_r;
        period_end  = 1'b0;
        ev          = 3'h0;
        wave_nxt    = wave_r;
        if (ctrl_r.run && src_tick) begin
            psc_nxt = psc_r + 10'h001;
        end
        if (!pwm) begin
            top_act_nxt = top_buf_r;
            cmp_act_nxt = cmp_buf_r;
        end
        if (tick) begin
            case (ctrl_r.mode) // RQ2
                htc_pkg::HTC_MODE_WDOG: begin
                    if (cnt_r == top_act_r) begin
                        cnt_nxt    = 16'h0000; // RQ13
                        period_end = 1'b1;
                    end else begin
                        cnt_nxt = cnt_r + 16'h0001; // RQ1
                    end
                    wave_nxt = (cnt_r == top_act_r) ^ ctrl_r.wave_inv; // RQ11
                end
                htc_pkg::HTC_MODE_CTC: begin
                    if (cnt_r == cmp_act_r) begin
                        cnt_nxt     = 16'h0000; // RQ13
                        ev.cmp      = 1'b1;
                        wave_nxt    = ~wave_r; // RQ11
                    end else if (cnt_r == 16'hffff) begin
                        cnt_nxt    = 16'h0000;
                        period_end = 1'b1;
                    end else begin
                        cnt_nxt = cnt_r + 16'h0001;
                    end
                end
                htc_pkg::HTC_MODE_FPWM: begin
                    if (cnt_r >= top_act_r) begin
                        cnt_nxt    = 16'h0000; // RQ13
                        period_end = 1'b1;
                    end else begin
                        cnt_nxt = cnt_r + 16'h0001;
                    end
                end
                htc_pkg::HTC_MODE_PFC: begin
                    if (!down_r) begin
                        if (cnt_r >= top_act_r) begin
                            down_nxt = (top_act_r != 16'h0000);
                            cnt_nxt  = (top_act_r != 16'h0000) ? top_act_r - 16'h0001 : 16'h0000;
                        end else begin
                            cnt_nxt = cnt_r + 16'h0001;
                        end
                    end else if (cnt_r == 16'h0000) begin
                        down_nxt   = 1'b0; // RQ1
                        cnt_nxt    = 16'h0001; // RQ13
                        period_end = 1'b1;
                    end else begin
                        cnt_nxt = cnt_r - 16'h0001; // RQ1
                    end
                end
                default: cnt_nxt = cnt_r;
            endcase
            ev.ovf = period_end; // RQ4
        end
        // pwm limits only swap at the period boundary or on a pin reset, so the edge never glitches
        if (pwm && period_end) begin
            top_act_nxt = top_buf_r; // RQ10
            cmp_act_nxt = cmp_buf_r; // RQ10
        end
        if (pwm && tick) begin
            ev.cmp   = (cnt_nxt == cmp_act_nxt);
            wave_nxt = (cnt_nxt < cmp_act_nxt) ^ ctrl_r.wave_inv; // RQ11
        end
        if (ctrl_r.cap_en && !pwm && cap_rise) begin
            cap_nxt = cnt_r; // RQ6
            ev.cap  = 1'b1; // RQ4
        end
        if (cnt_wr || sw_clr) begin
            cnt_nxt  = cnt_wr ? pwdata[15:0] : 16'h0000;
            down_nxt = 1'b0;
            psc_nxt  = 10'h000;
        end
        // events win over a clear in the same cycle
        stat_nxt = (stat_r & ~w1c) | setv | ev; // RQ8
        if (pin_rst) begin
            cnt_nxt     = 16'h0000;
            down_nxt    = 1'b0;
            psc_nxt     = 10'h000;
            wave_nxt    = ctrl_r.wave_inv;
            top_act_nxt = top_buf_r;
            cmp_act_nxt = cmp_buf_r;
            stat_nxt    = htc_pkg::IRQ_RST;
        end
        if (STANDALONE) begin
            irq_nxt = stat_nxt.ovf; // RQ7
        end else begin
            irq_nxt = |(stat_nxt & mask_r); // RQ8
        end
        wake_nxt = irq_nxt & ctrl_r.wake_en; // RQ5
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_r     <= 16'h0000;
            down_r    <= 1'b0;
            top_act_r <= TOP_INIT;
            cmp_act_r <= CMP_INIT;
            cap_r     <= 16'h0000;
            psc_r     <= 10'h000;
            wave_r    <= 1'b0;
            stat_r    <= htc_pkg::IRQ_RST;
            irq_r     <= 1'b0;
            wake_r    <= 1'b0;
        end else begin
            cnt_r     <= cnt_nxt;
            down_r    <= down_nxt;
            top_act_r <= top_act_nxt;
            cmp_act_r <= cmp_act_nxt;
            cap_r     <= cap_nxt;
            psc_r     <= psc_nxt;
            wave_r    <= wave_nxt;
            stat_r    <= stat_nxt;
            irq_r     <= irq_nxt;
            wake_r    <= wake_nxt;
        end
    end

    assign prdata           = prdata_r;
    assign pready           = pready_r;
    assign pslverr          = pslverr_r;
    assign timer_irq_out    = irq_r; // RQ5
    assign wake_irq_out     = wake_r; // RQ5
    assign compare_wave_out = wave_r; // RQ11
endmodule
`default_nettype wire

// >>> rtl/htc_pkg.sv
// Purpose: shared constants and types of the 16-bit timer/counter
// Assumes: 32-bit APB data, one register per aligned word
// Notes:   field positions below match the packed structs
package htc_pkg;
    localparam int          CNT_W        = 16;
    localparam int          ADDR_W       = 8;
    localparam int          PSC_W        = 10;
    localparam logic [3:0]  PSC_SEL_MAX  = 4'ha;

    // register byte offsets
    localparam logic [7:0]  OFS_CTRL     = 8'h00;
    localparam logic [7:0]  OFS_TOP      = 8'h04;
    localparam logic [7:0]  OFS_CMP      = 8'h08;
    localparam logic [7:0]  OFS_COUNT    = 8'h0c;
    localparam logic [7:0]  OFS_CAPTURE  = 8'h10;
    localparam logic [7:0]  OFS_IRQ_STAT = 8'h14;
    localparam logic [7:0]  OFS_IRQ_MASK = 8'h18;
    localparam logic [7:0]  OFS_IRQ_SET  = 8'h1c;
    localparam logic [7:0]  OFS_STATUS   = 8'h20;

    // control register fields
    localparam int          CTRL_MODE_LSB = 0;
    localparam int          CTRL_SRC_BIT  = 2;
    localparam int          CTRL_PSC_LSB  = 3;
    localparam int          CTRL_RUN_BIT  = 7;
    localparam int          CTRL_INV_BIT  = 8;
    localparam int          CTRL_CAP_BIT  = 9;
    localparam int          CTRL_WAKE_BIT = 10;
    localparam int          CTRL_W        = 11;
    localparam int          CTRL_RPE_BIT  = 11;
    localparam int          CTRL_CLR_BIT  = 12;

    // irq bit positions
    localparam int          IRQ_OVF_BIT  = 0;
    localparam int          IRQ_CMP_BIT  = 1;
    localparam int          IRQ_CAP_BIT  = 2;

    // status register fields
    localparam int          STAT_DIR_BIT = 0;
    localparam int          STAT_RUN_BIT = 1;

    // reset values
    localparam logic [10:0] CTRL_RST     = 11'h000;
    localparam logic [15:0] TOP_RST      = 16'hffff;
    localparam logic [15:0] CMP_RST      = 16'h0000;
    localparam logic [2:0]  IRQ_RST      = 3'h0;

    typedef enum logic [1:0] {
        HTC_MODE_WDOG = 2'b00,
        HTC_MODE_CTC  = 2'b01,
        HTC_MODE_FPWM = 2'b11,
        HTC_MODE_PFC  = 2'b10
    } htc_mode_type;

    typedef struct packed {
        logic         wake_en;
        logic         cap_en;
        logic         wave_inv;
        logic         run;
        logic [3:0]   psc_sel;
        logic         clk_src;
        htc_mode_type mode;
    } htc_ctrl_type;

    typedef struct packed {
        logic cap;
        logic cmp;
        logic ovf;
    } htc_irq_type;
endpackage

// >>> verification/htc_timer_monitor.sv
// Purpose: port checker for htc_timer
// Assumes: apb slave answers after one wait state
// Notes:   bound to every htc_timer instance
`timescale 1ns/1ps
`default_nettype none
module htc_timer_monitor (
    input wire logic        ref_clk,
    input wire logic        sys_rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        timer_reset_n,
    input wire logic        timer_irq_out,
    input wire logic        wake_irq_out
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
        else $error("pready late");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held");
    a_ready_cause: assert property (pready |-> psel && penable && $past(psel && penable))
        else $error("pready without access");
    a_err_decode: assert property (pready && paddr[1:0] == 2'b00 |-> pslverr == (paddr > 8'h20))
        else $error("pslverr wrong");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr alone");
    a_upper_zero: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000)
        else $error("upper read bits set");
    a_wake_needs_irq: assert property (wake_irq_out |-> timer_irq_out)
        else $error("wake without irq");
    a_pin_rst_quiet: assert property (!timer_reset_n [*6] |-> !timer_irq_out)
        else $error("irq during pin reset");
    a_irq_fall_cause: assert property ($fell(timer_irq_out) |-> $past(pready && pwrite, 1)
        || $past(pready && pwrite, 2) || $past(pready && pwrite, 3) || !$past(timer_reset_n, 3)
        || !$past(timer_reset_n, 4) || !$past(timer_reset_n, 5))
        else $error("irq fell without cause");

    c_wake: cover property (wake_irq_out);
    c_err: cover property (pslverr);
    c_irq_fall: cover property ($fell(timer_irq_out));
endmodule
bind htc_timer htc_timer_monitor i_mon (.ref_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .prdata,
    .pready, .pslverr, .timer_reset_n, .timer_irq_out, .wake_irq_out);
`default_nettype wire

// >>> verification/htc_apb_master.sv
// Purpose: apb master standing for the user logic
// Assumes: caller may enter xfer at any time
// Notes:   one idle cycle between transfers
`timescale 1ns/1ps
`default_nettype none
module htc_apb_master (
    input wire logic        ref_clk,
    output logic            psel,
    output logic            penable,
    output logic            pwrite,
    output logic [7:0]      paddr,
    output logic [31:0]     pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end

    // request held until pready seen high at an edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d;
    endtask
endmodule
`default_nettype wire

// >>> verification/htc_timer_tb_top.sv
// Purpose: self-checking bench for htc_timer
// Assumes: bus mode, registers reached through htc_apb_master
// Notes:   external count source held still where counts must be exact
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, x) begin tests_run++; if ((g) !== (x)) begin n_fail++; \
    $display("BAD t=%0t got %h exp %h", $time, (g), (x)); end end
module htc_timer_tb_top;
    logic        ref_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        psel, penable, pwrite, pready, pslverr, e;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic        timer_clock_in = 1'b0;
    logic        timer_reset_n = 1'b1;
    logic        capture_trigger_in = 1'b0;
    logic        timer_irq_out, wake_irq_out, compare_wave_out;
    logic        sa_irq;
    int          n_fail = 0;
    int          tests_run = 0;
    int          h, i;

    htc_timer i_dut (.ref_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .timer_clock_in, .timer_reset_n, .capture_trigger_in, .timer_irq_out, .wake_irq_out,
        .compare_wave_out);
    htc_apb_master i_mst (.ref_clk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
    // stand-alone copy: no bus, preloaded wdog run with a short period so overflow flags quickly
    htc_timer #(.STANDALONE(1'b1), .PRELOAD_CTRL(11'h080), .PRELOAD_TOP(16'h0003), .PRELOAD_CMP(16'h0001))
        i_dut_sa (.ref_clk, .sys_rst, .psel(1'b0), .penable(1'b0), .pwrite(1'b0), .paddr(8'h00),
        .pwdata(32'h00000000), .prdata(), .pready(), .pslverr(), .timer_clock_in, .timer_reset_n,
        .capture_trigger_in, .timer_irq_out(sa_irq), .wake_irq_out(), .compare_wave_out());

    always #2 ref_clk = ~ref_clk;

    task automatic conclude;
        $display("compares %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        i_mst.xfer(1'b1, a, d, r, e);
    endtask
    task automatic rd(input logic [7:0] a);
        i_mst.xfer(1'b0, a, 32'h0, q, e);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] x);
        rd(a);
        `CHK(q, x)
    endtask
    task automatic wait_irq;
        for (int k = 0; k < 200 && timer_irq_out !== 1'b1; k++) @(posedge ref_clk);
        `CHK(timer_irq_out, 1'b1)
    endtask
    task automatic wave_high(input int n);
        h = 0;
        repeat (n) begin
            @(posedge ref_clk);
            h += (compare_wave_out === 1'b1);
        end
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk);
        n_fail++;
        conclude();
    end

    initial begin
        repeat (8) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rdc(htc_pkg::OFS_CTRL, 32'h800);
        rdc(htc_pkg::OFS_TOP, 32'hffff);
        rdc(htc_pkg::OFS_IRQ_MASK, 32'h0);
        rd(8'h24);
        `CHK(e, 1'b1)
        $display("test reset_values done");
        `CHK(sa_irq, 1'b1)
        wr(htc_pkg::OFS_TOP, 32'h2);
        wr(htc_pkg::OFS_IRQ_MASK, 32'h1);
        wr(htc_pkg::OFS_CTRL, 32'h80);
        wait_irq();
        rd(htc_pkg::OFS_COUNT);
        `CHK(q[15:0] <= 16'h0002, 1'b1)
        wr(htc_pkg::OFS_CTRL, 32'h0);
        wr(htc_pkg::OFS_IRQ_STAT, 32'h7);
        rdc(htc_pkg::OFS_IRQ_STAT, 32'h0);
        for (i = 0; i < 3; i++) begin
            wr(htc_pkg::OFS_IRQ_SET, 32'h1 << i);
            rdc(htc_pkg::OFS_IRQ_STAT, 32'h1 << i);
            wr(htc_pkg::OFS_IRQ_STAT, 32'h1 << i);
        end
        wr(htc_pkg::OFS_IRQ_SET, 32'h1);
        wr(htc_pkg::OFS_CTRL, 32'h400);
        repeat (3) @(posedge ref_clk);
        `CHK(wake_irq_out, 1'b1)
        wr(htc_pkg::OFS_IRQ_MASK, 32'h0);
        repeat (3) @(posedge ref_clk);
        `CHK(timer_irq_out, 1'b0)
        $display("test irq done");
        wr(htc_pkg::OFS_CMP, 32'h3);
        wr(htc_pkg::OFS_CTRL, 32'h81);
        repeat (6) begin
            rd(htc_pkg::OFS_COUNT);
            `CHK(q[15:0] <= 16'h0003, 1'b1)
        end
        rd(htc_pkg::OFS_IRQ_STAT);
        `CHK(q[1], 1'b1)
        wr(htc_pkg::OFS_TOP, 32'h5);
        wr(htc_pkg::OFS_CTRL, 32'h82);
        q = 32'h0;
        for (i = 0; i < 20 && q[0] !== 1'b1; i++) rd(htc_pkg::OFS_STATUS);
        `CHK(q[0], 1'b1)
        wr(htc_pkg::OFS_IRQ_STAT, 32'h7);
        repeat (12) @(posedge ref_clk);
        rd(htc_pkg::OFS_IRQ_STAT);
        `CHK(q[0], 1'b1)
        $display("test ctc_pfc done");
        wr(htc_pkg::OFS_CMP, 32'h4);
        wr(htc_pkg::OFS_TOP, 32'h9);
        wr(htc_pkg::OFS_CTRL, 32'h83);
        repeat (20) @(posedge ref_clk);
        wave_high(100);
        `CHK(h, 40)
        wr(htc_pkg::OFS_CTRL, 32'h183);
        wr(htc_pkg::OFS_TOP, 32'h13);
        repeat (40) @(posedge ref_clk);
        wave_high(200);
        `CHK(h, 160)
        $display("test pwm done");
        wr(htc_pkg::OFS_TOP, 32'hffff);
        wr(htc_pkg::OFS_CTRL, 32'h98);
        wr(htc_pkg::OFS_COUNT, 32'h0);
        repeat (80) @(posedge ref_clk);
        rd(htc_pkg::OFS_COUNT);
        `CHK(q[15:0] >= 16'h0009 && q[15:0] <= 16'h000c, 1'b1)
        wr(htc_pkg::OFS_CTRL, 32'h84);
        wr(htc_pkg::OFS_COUNT, 32'h0);
        repeat (5) begin
            timer_clock_in <= 1'b1;
            repeat (4) @(posedge ref_clk);
            timer_clock_in <= 1'b0;
            repeat (4) @(posedge ref_clk);
        end
        rdc(htc_pkg::OFS_COUNT, 32'h5);
        $display("test clock_source done");
        wr(htc_pkg::OFS_CTRL, 32'h284);
        wr(htc_pkg::OFS_COUNT, 32'h1234);
        wr(htc_pkg::OFS_IRQ_MASK, 32'h4);
        for (i = 0; i < 2; i++) begin
            capture_trigger_in <= 1'b1;
            repeat (4) @(posedge ref_clk);
            capture_trigger_in <= 1'b0;
            if (i == 0) begin
                wait_irq();
                rdc(htc_pkg::OFS_CAPTURE, 32'h1234);
                wr(htc_pkg::OFS_IRQ_STAT, 32'h7);
                wr(htc_pkg::OFS_CTRL, 32'h287);
            end
        end
        repeat (10) @(posedge ref_clk);
        rdc(htc_pkg::OFS_IRQ_STAT, 32'h0);
        wr(htc_pkg::OFS_IRQ_SET, 32'h7);
        timer_reset_n <= 1'b0;
        repeat (8) @(posedge ref_clk);
        `CHK(sa_irq, 1'b0)
        `CHK(timer_irq_out, 1'b0)
        timer_reset_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        rdc(htc_pkg::OFS_IRQ_STAT, 32'h0);
        rdc(htc_pkg::OFS_COUNT, 32'h0);
        $display("test capture_pin_reset done");
        conclude();
    end
endmodule
`default_nettype wire
